//--- design/tca_pkg.sv
package tca_pkg;
  localparam int NUM_MOD = 5;
  localparam int WDOG_MOD = 4;
  localparam int DIV_SLOW = 6;
  localparam int DIV_FAST = 2;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_CNT_LO = 8'h02;
  localparam logic [7:0] ADDR_CNT_HI = 8'h03;
  localparam logic [7:0] ADDR_MM_BASE = 8'h10;
  localparam logic [7:0] ADDR_CL_BASE = 8'h20;
  localparam logic [7:0] ADDR_CH_BASE = 8'h30;
  localparam logic [1:0] SRC_DIV6 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_T0 = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam int MB_IDLE = 7;
  localparam int MB_WDOG = 6;
  localparam int MB_SRC_HI = 2;
  localparam int MB_SRC_LO = 1;
  localparam int MB_OVF_IE = 0;
  localparam int CB_OVF = 7;
  localparam int CB_RUN = 6;
  localparam int MM_CMP = 6;
  localparam int MM_RISE = 5;
  localparam int MM_FALL = 4;
  localparam int MM_MAT = 3;
  localparam int MM_TOG = 2;
  localparam int MM_PWM = 1;
  localparam int MM_IE = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
endpackage : tca_pkg

//--- design/tca_timing_array.sv
// Function
// - time base counts one of four sources
// - select 01 div2, 10 timer0 overflow
// - one shared 16-bit counter for all
// - all flags share one interrupt output
// - count on P1.2, modules on P1.3-7
// - idle-halt bit stops counting in idle
// - counter runs only with run bit
// - overflow sets flag, software-only clear
// - module flag set on match/capture
// - capture, timer, toggle output, pwm modes
// - module irq enable gates its flag
// - comparator enable activates compare
// - match flag enable sets event flag
// - toggle enable inverts line on match
// - pwm enable selects pwm mode
// - pwm low below compare, else high
// - pwm reload low from high on wrap
// - rising/falling edge enables for capture
// - capture copies counter on valid edge
// - event irq needs flag and enable
// - module 4 watchdog arm bit
// - watchdog match gives internal reset
module tca_timing_array #(
  parameter int NUM_MOD_P = tca_pkg::NUM_MOD
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cpu_idle,
  input wire logic timer0_ovf,
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  output logic irq,
  output logic wdog_reset
);
  import tca_pkg::*;

  // port 1 positions of the count pin and of module 0's line
  localparam int PIN_CNT = 2;
  localparam int PIN_MOD0 = 3;
  // all-ones marks: the counter wraps and the pwm low byte wraps here
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [7:0] LOW_TOP = 8'hff;

  //////////////////////////////////////////////////////////////////////////
  // control registers
  logic idle_halt_ctl_q, wdog_arm_q, overflow_irq_en_q;
  logic source_select_hi_q, source_select_lo_q;
  logic overflow_flag_q, run_control_bit_q;
  logic [NUM_MOD_P-1:0] module_event_flag_q;
  logic [6:0] module_mode_reg_q [NUM_MOD_P];
  logic [7:0] capture_low_byte_q [NUM_MOD_P];
  logic [7:0] capture_high_byte_q [NUM_MOD_P];
  logic [15:0] count_q;
  logic [NUM_MOD_P-1:0] line_q;
  // software sees the counter bytes live; no latch pairs the two halves

  function automatic logic is_mod(input logic [7:0] a, input logic [7:0] b,
                                  input int n);
    is_mod = (a >= b) && (a < b + 8'(n));
  endfunction : is_mod

  // register offset within a per-module bank; callers check the range
  function automatic logic [2:0] mod_idx(input logic [7:0] a,
                                         input logic [7:0] b);
    mod_idx = 3'(a - b);
  endfunction : mod_idx

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [NUM_MOD_P:0] sync1_q, sync2_q, sync3_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      // bit 0 is the count pin P1.2, bits above are P1.3..P1.7
      sync1_q <= port1_in[PIN_CNT +: NUM_MOD_P+1];
      sync2_q <= sync1_q;
      // edge history only: never read the first stage, it may be metastable
      sync3_q <= sync2_q;
    end
  end

  // each pin change shows as a single-cycle edge, two clocks late
  logic [NUM_MOD_P:0] rise, fall;
  assign rise = sync2_q & ~sync3_q;
  assign fall = ~sync2_q & sync3_q;

  //////////////////////////////////////////////////////////////////////////
  // prescalers and source select
  // free-running: the divide phase is not tied to the run bit
  logic [2:0] div6_q;
  logic div2_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div6_q <= '0;
      div2_q <= 1'b0;
    end else begin
      div6_q <= (div6_q == 3'(DIV_SLOW - 1)) ? 3'h0 : div6_q + 3'h1;
      div2_q <= ~div2_q;
    end
  end

  // div2 ticks every other clock, div6 on its last phase
  logic src_tick;
  always_comb begin
    unique case ({source_select_hi_q, source_select_lo_q})
      SRC_DIV6: src_tick = (div6_q == 3'(DIV_SLOW - 1));
      SRC_DIV2: src_tick = div2_q;
      SRC_T0: src_tick = timer0_ovf;
      SRC_EXT: src_tick = rise[0];
    endcase
  end

  logic cnt_en;
  // idle gating is a level: the count resumes on the tick after idle ends
  assign cnt_en = run_control_bit_q && !(idle_halt_ctl_q && cpu_idle)
                  && src_tick;

  logic wr_cnt_lo, wr_cnt_hi;
  assign wr_cnt_lo = reg_wr && reg_addr == ADDR_CNT_LO;
  assign wr_cnt_hi = reg_wr && reg_addr == ADDR_CNT_HI;
  logic ovf;
  // the wrap is seen on the wrapping tick itself, while the counter still holds all ones
  assign ovf = cnt_en && (count_q == CNT_TOP);

  // software writes win over a tick in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_q <= RST_WORD;
    end else if (wr_cnt_lo) begin
      count_q[7:0] <= reg_wdata;
    end else if (wr_cnt_hi) begin
      count_q[15:8] <= reg_wdata;
    end else if (cnt_en) begin
      count_q <= count_q + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-module compare / capture
  logic [NUM_MOD_P-1:0] match, cap_ev, pwm_lvl, low_wrap;
  assign low_wrap = {NUM_MOD_P{cnt_en && count_q[7:0] == LOW_TOP}};
  always_comb begin
    for (int i = 0; i < NUM_MOD_P; i++) begin
      // compare only once per tick so a match acts once
      match[i] = module_mode_reg_q[i][MM_CMP] && cnt_en &&
                 !module_mode_reg_q[i][MM_PWM] &&
                 (count_q + 16'h0001 ==
                  {capture_high_byte_q[i], capture_low_byte_q[i]});
      cap_ev[i] = (module_mode_reg_q[i][MM_RISE] && rise[i+1]) ||
                  (module_mode_reg_q[i][MM_FALL] && fall[i+1]);
      pwm_lvl[i] = !(count_q[7:0] < capture_low_byte_q[i]);
    end
  end

  // per-module write strobes for the compare/capture byte banks
  logic [NUM_MOD_P-1:0] wr_cl, wr_ch;
  always_comb begin
    for (int i = 0; i < NUM_MOD_P; i++) begin
      wr_cl[i] = reg_wr && reg_addr == ADDR_CL_BASE + 8'(i);
      wr_ch[i] = reg_wr && reg_addr == ADDR_CH_BASE + 8'(i);
    end
  end

  // a capture edge wins over a software write in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_MOD_P; i++) begin
        capture_low_byte_q[i] <= RST_BYTE;
        capture_high_byte_q[i] <= RST_BYTE;
      end
    end else begin
      for (int i = 0; i < NUM_MOD_P; i++) begin
        if (cap_ev[i]) begin
          capture_low_byte_q[i] <= count_q[7:0];
          capture_high_byte_q[i] <= count_q[15:8];
        end else begin
          if (wr_cl[i]) begin
            capture_low_byte_q[i] <= reg_wdata;
          end else if (module_mode_reg_q[i][MM_PWM] && low_wrap[i]) begin
            capture_low_byte_q[i] <= capture_high_byte_q[i];
          end
          if (wr_ch[i]) begin
            capture_high_byte_q[i] <= reg_wdata;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_MOD_P; i++) begin
        module_mode_reg_q[i] <= '0;
      end
    end else if (reg_wr && is_mod(reg_addr, ADDR_MM_BASE, NUM_MOD_P)) begin
      // writes outside the bank are dropped by the range check
      module_mode_reg_q[mod_idx(reg_addr, ADDR_MM_BASE)] <= reg_wdata[6:0];
    end
  end

  // output lines: toggle on match, or the pwm level
  // a line in pwm mode ignores the toggle bit; its level lags by one clock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_q <= '0;
    end else begin
      for (int i = 0; i < NUM_MOD_P; i++) begin
        if (module_mode_reg_q[i][MM_PWM] && module_mode_reg_q[i][MM_CMP]) begin
          line_q[i] <= pwm_lvl[i];
        end else if (match[i] && module_mode_reg_q[i][MM_TOG]) begin
          line_q[i] <= ~line_q[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mode and control registers, flags
  logic wr_mode, wr_ctrl;
  assign wr_mode = reg_wr && reg_addr == ADDR_MODE;
  assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idle_halt_ctl_q <= 1'b0;
      wdog_arm_q <= 1'b0;
      source_select_hi_q <= 1'b0;
      source_select_lo_q <= 1'b0;
      overflow_irq_en_q <= 1'b0;
    end else if (wr_mode) begin
      idle_halt_ctl_q <= reg_wdata[MB_IDLE];
      wdog_arm_q <= reg_wdata[MB_WDOG];
      source_select_hi_q <= reg_wdata[MB_SRC_HI];
      source_select_lo_q <= reg_wdata[MB_SRC_LO];
      overflow_irq_en_q <= reg_wdata[MB_OVF_IE];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_control_bit_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_control_bit_q <= reg_wdata[CB_RUN];
    end
  end

  // a hardware set in the same cycle as a clear wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      overflow_flag_q <= 1'b0;
    end else if (ovf) begin
      overflow_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      overflow_flag_q <= reg_wdata[CB_OVF];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // a written one sets a flag as well; only a written zero clears it
      module_event_flag_q <= '0;
    end else begin
      for (int i = 0; i < NUM_MOD_P; i++) begin
        if ((match[i] && module_mode_reg_q[i][MM_MAT]) || cap_ev[i]) begin
          module_event_flag_q[i] <= 1'b1;
        end else if (wr_ctrl) begin
          module_event_flag_q[i] <= reg_wdata[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared interrupt and watchdog
  logic [NUM_MOD_P-1:0] mod_ie;
  always_comb begin
    for (int i = 0; i < NUM_MOD_P; i++) begin
      mod_ie[i] = module_mode_reg_q[i][MM_IE];
    end
  end

  // flags stay set after their cause; software clears them in the ctrl byte
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(module_event_flag_q & mod_ie) ||
             (overflow_flag_q && overflow_irq_en_q);
    end
  end

  // one-cycle internal reset pulse; the reset pin is never driven
  logic wdog_hit;
  assign wdog_hit = wdog_arm_q && match[WDOG_MOD];
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wdog_reset <= 1'b0;
    end else begin
      wdog_reset <= wdog_hit;
    end
  end

  // pins not driven by a module stay general i/o
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port1_out <= '0;
      port1_oe <= '0;
    end else begin
      port1_out <= '0;
      port1_oe <= '0;
      for (int i = 0; i < NUM_MOD_P; i++) begin
        port1_out[PIN_MOD0+i] <= line_q[i];
        port1_oe[PIN_MOD0+i] <= module_mode_reg_q[i][MM_TOG] ||
                         module_mode_reg_q[i][MM_PWM];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port
  // the mux is decoded apart from the flop so reg_rdata stays a plain
  // register that is zero outside the answer cycle
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = RST_BYTE;
    if (reg_addr == ADDR_MODE) begin
      rd_mux = {idle_halt_ctl_q, wdog_arm_q, 3'h0, source_select_hi_q,
                source_select_lo_q, overflow_irq_en_q};
    end else if (reg_addr == ADDR_CTRL) begin
      rd_mux = {overflow_flag_q, run_control_bit_q, 1'b0,
                5'(module_event_flag_q)};
    end else if (reg_addr == ADDR_CNT_LO) begin
      rd_mux = count_q[7:0];
    end else if (reg_addr == ADDR_CNT_HI) begin
      rd_mux = count_q[15:8];
    end else if (is_mod(reg_addr, ADDR_MM_BASE, NUM_MOD_P)) begin
      rd_mux = {1'b0, module_mode_reg_q[mod_idx(reg_addr, ADDR_MM_BASE)]};
    end else if (is_mod(reg_addr, ADDR_CL_BASE, NUM_MOD_P)) begin
      rd_mux = capture_low_byte_q[mod_idx(reg_addr, ADDR_CL_BASE)];
    end else if (is_mod(reg_addr, ADDR_CH_BASE, NUM_MOD_P)) begin
      rd_mux = capture_high_byte_q[mod_idx(reg_addr, ADDR_CH_BASE)];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= RST_BYTE;
    end
  end
endmodule : tca_timing_array

//--- tb/tca_timing_array_assertions.sv
module tca_timing_array_assertions #(
  parameter int NUM_MOD_P = tca_pkg::NUM_MOD
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_idle,
  input wire logic timer0_ovf,
  input wire logic [7:0] port1_in,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic irq,
  input wire logic wdog_reset
);
  import tca_pkg::*;
  // shadow of the control bits, rebuilt from the writes seen at the ports
  logic [7:0] mode_q;
  logic run_q;
  logic [4:0] ie_q;
  logic halted;
  assign halted = !run_q || (mode_q[MB_IDLE] && cpu_idle);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= 8'h00;
      run_q <= 1'b0;
      ie_q <= 5'h00;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MODE) mode_q <= reg_wdata;
      if (reg_addr == ADDR_CTRL) run_q <= reg_wdata[CB_RUN];
      for (int i = 0; i < NUM_MOD_P; i++) begin
        if (reg_addr == ADDR_MM_BASE + 8'(i)) ie_q[i] <= reg_wdata[MM_IE];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence rd_lo_twice;
    reg_rd && reg_addr == ADDR_CNT_LO && halted ##1 !reg_wr
      ##1 reg_rd && reg_addr == ADDR_CNT_LO;
  endsequence
  sequence rd_ctrl_twice;
    reg_rd && reg_addr == ADDR_CTRL ##1 !reg_wr
      ##1 reg_rd && reg_addr == ADDR_CTRL;
  endsequence
  halt_still_a: assert property (
    rd_lo_twice |=> reg_rdata == $past(reg_rdata, 2))
    else $error("count moved while halted");
  flags_keep_a: assert property (
    rd_ctrl_twice |=> ($past(reg_rdata, 2) & ~reg_rdata & 8'h9f) == 8'h00)
    else $error("flag cleared without a write");
  rd_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  wdog_pulse_a: assert property (wdog_reset |=> !wdog_reset)
    else $error("watchdog reset longer than one cycle");
  wdog_arm_a: assert property (
    wdog_reset |-> $past(mode_q[MB_WDOG]) || $past(mode_q[MB_WDOG], 2))
    else $error("watchdog reset while disarmed");
  pins_low_a: assert property (
    port1_oe[2:0] == 3'h0 && port1_out[2:0] == 3'h0)
    else $error("array drove a pin it does not own");
  oe_tog_a: assert property (
    reg_wr && reg_addr == ADDR_MM_BASE && reg_wdata[MM_TOG]
      |-> ##[1:2] port1_oe[3])
    else $error("toggle line not enabled");
  irq_en_a: assert property (
    irq |-> $past(mode_q[MB_OVF_IE]) || $past(|ie_q))
    else $error("interrupt with no enable set");
endmodule : tca_timing_array_assertions

//--- tb/tca_pin_model.sv
module tca_pin_model (
  input wire logic ext_level,
  input wire logic [4:0] line_level,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  output logic [7:0] port1_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // spare bits idle high on their pull-ups
  assign port1_in[1:0] = 2'h3;
  assign port1_in[2] = ext_level;
  // a driven line reads back its own level, else the far end sets it
  assign port1_in[7:3] = (port1_oe[7:3] & port1_out[7:3]) |
    (~port1_oe[7:3] & line_level);
endmodule : tca_pin_model

//--- tb/tca_timing_array_bench.sv
`define chk(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tca_timing_array_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tca_pkg::*;
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cpu_idle = 0;
  logic timer0_ovf = 0, ext = 0, irq, wdog_reset, wd_seen = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] port1_in, port1_out, port1_oe;
  logic [4:0] line = 5'h00;
  logic [7:0] ra[8] = '{ADDR_MODE, ADDR_CTRL, ADDR_CNT_LO, ADDR_CNT_HI,
    ADDR_MM_BASE, ADDR_CL_BASE, ADDR_CH_BASE, 8'h7f};
  logic [1:0] srcs[5] = '{SRC_DIV6, SRC_DIV2, SRC_T0, SRC_EXT, SRC_DIV2};
  logic [7:0] exps[5] = '{8'h0a, 8'h1e, 8'h07, 8'h05, 8'h00};
  int n_errors = 0;
  int checks = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (wdog_reset === 1'b1) wd_seen <= 1'b1;
  tca_timing_array i_tca_timing_array (.mclk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_idle, .timer0_ovf,
    .port1_in, .port1_out, .port1_oe, .irq, .wdog_reset);
  tca_pin_model i_tca_pin_model (.ext_level(ext), .line_level(line),
    .port1_out, .port1_oe, .port1_in);
  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic ck(input logic [7:0] a, input logic [7:0] e, string n);
    logic [7:0] v;
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    `chk(n, e, v)
  endtask : ck
  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    wr(8'h7f, 8'hff);
    foreach (ra[i]) ck(ra[i], 8'h00, "reset");
    // 60-cycle run window: a whole number of prescaler periods
    for (int s = 0; s < 5; s++) begin
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_MODE, {s == 4, 4'h0, srcs[s], 1'b0});
      cpu_idle <= (s == 4);
      wr(ADDR_CTRL, 8'h40);
      for (int k = 0; k < 58; k++) begin
        @(posedge mclk);
        timer0_ovf <= (s == 2) && (k % 8 == 0) && (k < 56);
        ext <= (s == 3) && (k % 8 < 4) && (k < 40);
      end
      wr(ADDR_CTRL, 8'h00);
      ck(ADDR_CNT_LO, exps[s], "count");
      ck(ADDR_CNT_LO, exps[s], "count held");
      ck(ADDR_CNT_HI, 8'h00, "count hi");
    end
    cpu_idle <= 1'b0;
    wr(ADDR_CNT_LO, 8'hff);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_CTRL, 8'h40);
    repeat (6) @(posedge mclk);
    // timer0 source with no pulses freezes the count without a ctrl write
    wr(ADDR_MODE, 8'h05);
    ck(ADDR_CTRL, 8'hc0, "overflow");
    ck(ADDR_CTRL, 8'hc0, "overflow kept");
    `chk("irq ovf", 1'b1, irq)
    wr(ADDR_MODE, 8'h04);
    repeat (2) @(posedge mclk);
    `chk("irq masked", 1'b0, irq)
    wr(ADDR_CL_BASE, 8'h05);
    wr(ADDR_CH_BASE, 8'h00);
    wr(ADDR_CL_BASE + 8'h04, 8'h05);
    wr(ADDR_CH_BASE + 8'h04, 8'h00);
    wr(ADDR_MM_BASE, 8'h4d);
    wr(ADDR_MM_BASE + 8'h04, 8'h40);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_MODE, 8'h42);
    repeat (16) @(posedge mclk);
    wr(ADDR_MODE, 8'h04);
    ck(ADDR_CTRL, 8'h41, "match flag");
    `chk("toggle", 1'b1, port1_out[3])
    `chk("irq match", 1'b1, irq)
    `chk("watchdog", 1'b1, wd_seen)
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_MM_BASE + 8'h01, 8'h42);
    wr(ADDR_CL_BASE + 8'h01, 8'h80);
    wr(ADDR_CH_BASE + 8'h01, 8'h10);
    wr(ADDR_CNT_LO, 8'h7f);
    repeat (3) @(posedge mclk);
    `chk("pwm low", 1'b0, port1_out[4])
    wr(ADDR_CNT_LO, 8'h80);
    repeat (3) @(posedge mclk);
    `chk("pwm high", 1'b1, port1_out[4])
    wr(ADDR_CNT_LO, 8'hff);
    wr(ADDR_MODE, 8'h02);
    repeat (4) @(posedge mclk);
    wr(ADDR_MODE, 8'h04);
    ck(ADDR_CL_BASE + 8'h01, 8'h10, "pwm reload");
    `chk("pwm wrap", 1'b0, port1_out[4])
    wr(ADDR_MM_BASE + 8'h02, 8'h21);
    wr(ADDR_CNT_LO, 8'h34);
    wr(ADDR_CNT_HI, 8'h12);
    line[2] <= 1'b1;
    repeat (6) @(posedge mclk);
    ck(ADDR_CL_BASE + 8'h02, 8'h34, "capture lo");
    ck(ADDR_CH_BASE + 8'h02, 8'h12, "capture hi");
    ck(ADDR_CTRL, 8'h44, "capture flag");
    wr(ADDR_CNT_LO, 8'h56);
    line[2] <= 1'b0;
    repeat (6) @(posedge mclk);
    ck(ADDR_CL_BASE + 8'h02, 8'h34, "fall ignored");
    // falling edge only: the rise must not capture, the fall must
    wr(ADDR_MM_BASE + 8'h02, 8'h11);
    wr(ADDR_CNT_LO, 8'h78);
    line[2] <= 1'b1;
    repeat (6) @(posedge mclk);
    ck(ADDR_CL_BASE + 8'h02, 8'h34, "rise ignored");
    line[2] <= 1'b0;
    repeat (6) @(posedge mclk);
    ck(ADDR_CL_BASE + 8'h02, 8'h78, "fall capture");
    stop_test();
  end
endmodule : tca_timing_array_bench
bind tca_timing_array tca_timing_array_assertions #(.NUM_MOD_P(NUM_MOD_P))
  i_chk (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .cpu_idle, .timer0_ovf, .port1_in, .port1_out, .port1_oe,
  .irq, .wdog_reset);
